// *** hdl/ahl_pkg.sv ***
/*
 * Package of the error header log and secondary error status block.
 * Holds byte offsets, field layouts, reset values and access masks.
 * Assumes a 32-bit AHB-Lite register bus and one clock domain.
 */
package ahl_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int FLAG_W = 14;
    localparam int HDR_W = 128;
    localparam int PTR_W = 5;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [11:0] OFS_HDR_WORD0 = 12'h11C;
    localparam logic [11:0] OFS_HDR_WORD1 = 12'h120;
    localparam logic [11:0] OFS_HDR_WORD2 = 12'h124;
    localparam logic [11:0] OFS_HDR_WORD3 = 12'h128;
    localparam logic [11:0] OFS_SEC_FLAGS = 12'h12C;
    localparam logic [11:0] OFS_SEC_MASK = 12'h130;
    localparam logic [11:0] OFS_SEC_SEVERITY = 12'h134;
    localparam logic [11:0] OFS_SEC_FIRST_PTR = 12'h138;

    // ************************************************************
    // flag bit positions
    // ************************************************************
    localparam int BIT_INTERNAL_BRIDGE_FAULT = 13;
    localparam int BIT_SYSTEM_ERROR_SEEN = 12;
    localparam int BIT_PARITY_ERROR_SEEN = 11;
    localparam int BIT_DELAYED_TXN_TIMER_EXPIRED = 10;
    localparam int BIT_ADDRESS_FAULT = 9;
    localparam int BIT_ATTRIBUTE_FAULT = 8;
    localparam int BIT_DATA_FAULT = 7;
    localparam int BIT_SPLIT_MSG_DATA_FAULT = 6;
    localparam int BIT_UNEXPECTED_SPLIT_COMPLETION = 5;
    localparam int BIT_GOT_MASTER_ABORT = 3;
    localparam int BIT_GOT_TARGET_ABORT = 2;
    localparam int BIT_SPLIT_MASTER_ABORT = 1;
    localparam int BIT_SPLIT_TARGET_ABORT = 0;

    // ************************************************************
    // reset values and access masks
    // ************************************************************
    localparam logic [31:0] RST_HDR_WORD = 32'h0000_0000;
    localparam logic [13:0] RST_SEC_FLAGS = 14'h0000;
    localparam logic [13:0] RST_SEC_MASK = 14'h17A8;
    localparam logic [13:0] RST_SEC_SEVERITY = 14'h1340;
    localparam logic [4:0] RST_FIRST_PTR = 5'h00;
    // bits 12..0 except reserved bit 4; bit 13 is never set
    localparam logic [13:0] FLAG_SETTABLE = 14'h1FEF;
    // mask and severity: bits 13..0 except reserved bit 4
    localparam logic [13:0] CTRL_WRITABLE = 14'h3FEF;
    // flags that capture a header: all settable except bits 12 and 10
    localparam logic [13:0] FLAG_HDR_LOGGING = 14'h0BEF;

    // ************************************************************
    // bus encodings
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** hdl/ahl_ahb_slv.sv ***
/*
 * AHB-Lite slave front end: accepts single word transfers with no wait
 * state, hands out a read strobe in the address phase and a write strobe
 * in the data phase. Assumes a single master and hready tied to hreadyout.
 */
`timescale 1ns/1ps
module ahl_ahb_slv (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite address phase
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // ahb-lite response
    output logic hreadyout,
    output logic hresp,
    // register side
    output logic rd_en,
    output logic [11:0] rd_addr,
    output logic wr_en,
    output logic [11:0] wr_addr
);

    // ************************************************************
    // address phase decode
    // ************************************************************
    logic accept;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;

    // htrans[1] covers NONSEQ and SEQ; only word transfers do anything
    assign accept = hsel & hready & htrans[1] & (hsize == ahl_pkg::HSIZE_WORD);
    assign rd_en = accept & ~hwrite;
    assign rd_addr = haddr;
    assign wr_en = wr_pend_r;
    assign wr_addr = wr_addr_r;

    // ************************************************************
    // write data phase
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= accept & hwrite;
            if (accept & hwrite) begin
                wr_addr_r <= haddr;
            end
        end
    end

    // ************************************************************
    // response: ready from the first edge after reset, always okay
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= ahl_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= ahl_pkg::HRESP_OKAY;
        end
    end

endmodule

// *** hdl/ahl_top.sv ***
/*
 * Error header log and secondary uncorrectable error status block.
 * Holds the four header log words, the secondary flag, mask, severity
 * and first error pointer registers behind an AHB-Lite slave.
 * Assumes error events are one-cycle pulses synchronous to hclk and that
 * hresetn is the power-on reset: every register here is sticky, so a
 * lesser reset elsewhere in the chip must not reach this block.
 */
`timescale 1ns/1ps

module ahl_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // secondary error events, one pulse per flag position
    input wire logic [13:0] err_event,
    input wire logic [127:0] err_header,
    // error reports towards the upstream port
    output logic report_fatal_r,
    output logic report_nonfatal_r
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic rd_en;
    logic [11:0] rd_addr;
    logic wr_en;
    logic [11:0] wr_addr;

    logic [31:0] hdr_word_r [0:3];
    logic [13:0] flags_r;
    logic [13:0] flags_nxt;
    logic [13:0] mask_r;
    logic [13:0] sev_r;
    logic [4:0] first_ptr_r;
    logic ptr_valid_r;
    logic [4:0] hdr_owner_r;
    logic hdr_locked_r;
    logic [31:0] hrdata_r;

    logic [13:0] ev;
    logic [13:0] ev_hdr;
    logic [13:0] ev_rep;
    logic [13:0] w1c;
    logic wr_flags;
    logic wr_mask;
    logic wr_sev;
    logic hdr_free;
    logic ptr_free;

    // ************************************************************
    // helpers
    // ************************************************************
    // lowest set flag wins when several errors land in one cycle
    function automatic logic [4:0] lowest_bit(input logic [13:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 13; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic flag_at(input logic [13:0] v, input logic [4:0] idx);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 14; i++) begin
            if (5'(i) == idx) begin
                hit = v[i];
            end
        end
        return hit;
    endfunction

    // ************************************************************
    // bus front end
    // ************************************************************
    ahl_ahb_slv u_slv (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .wr_en(wr_en),
        .wr_addr(wr_addr)
    );

    assign wr_flags = wr_en & (wr_addr == ahl_pkg::OFS_SEC_FLAGS);
    assign wr_mask = wr_en & (wr_addr == ahl_pkg::OFS_SEC_MASK);
    assign wr_sev = wr_en & (wr_addr == ahl_pkg::OFS_SEC_SEVERITY);

    // ************************************************************
    // event qualification
    // ************************************************************
    // bit 13 and reserved bit 4 can never set, whatever the source drives
    assign ev = err_event & ahl_pkg::FLAG_SETTABLE;
    // bits 12 and 10 are left out of the header capture
    assign ev_hdr = ev & ahl_pkg::FLAG_HDR_LOGGING;
    assign ev_rep = ev & ~mask_r;

    // ************************************************************
    // secondary flags
    // ************************************************************
    assign w1c = wr_flags ? (hwdata[13:0] & ahl_pkg::FLAG_SETTABLE) : 14'h0000;

    // a set arriving with its own clear wins, so no event is lost
    always_comb begin
        flags_nxt = (flags_r & ~w1c) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= ahl_pkg::RST_SEC_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ************************************************************
    // mask and severity
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= ahl_pkg::RST_SEC_MASK;
        end else if (wr_mask) begin
            mask_r <= hwdata[13:0] & ahl_pkg::CTRL_WRITABLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sev_r <= ahl_pkg::RST_SEC_SEVERITY;
        end else if (wr_sev) begin
            sev_r <= hwdata[13:0] & ahl_pkg::CTRL_WRITABLE;
        end
    end

    // ************************************************************
    // header log capture
    // ************************************************************
    // the log frees up once the flag that filled it reads clear again;
    // a fresh error in that very cycle may refill it at once
    assign hdr_free = ~hdr_locked_r | ~flag_at(flags_nxt, hdr_owner_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hdr_locked_r <= 1'b0;
            hdr_owner_r <= 5'h00;
        end else if (hdr_free && (ev_hdr != 14'h0000)) begin
            hdr_locked_r <= 1'b1;
            hdr_owner_r <= lowest_bit(ev_hdr);
        end else if (hdr_free) begin
            hdr_locked_r <= 1'b0;
        end
    end

    // word k carries header bits 127-32k down to 96-32k, top byte first
    for (genvar k = 0; k < 4; k++) begin : g_hdr
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                hdr_word_r[k] <= ahl_pkg::RST_HDR_WORD;
            end else if (hdr_free && (ev_hdr != 14'h0000)) begin
                hdr_word_r[k] <= err_header[127 - 32 * k -: 32];
            end
        end
    end

    // ************************************************************
    // first error pointer
    // ************************************************************
    // only unmasked errors count as reported; the pointer stays put
    // until software clears the flag it names
    assign ptr_free = ~ptr_valid_r | ~flag_at(flags_nxt, first_ptr_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_ptr_r <= ahl_pkg::RST_FIRST_PTR;
            ptr_valid_r <= 1'b0;
        end else if (ptr_free && (ev_rep != 14'h0000)) begin
            first_ptr_r <= lowest_bit(ev_rep);
            ptr_valid_r <= 1'b1;
        end else if (ptr_free) begin
            ptr_valid_r <= 1'b0;
        end
    end

    // ************************************************************
    // error reports
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            report_fatal_r <= 1'b0;
            report_nonfatal_r <= 1'b0;
        end else begin
            report_fatal_r <= |(ev_rep & sev_r);
            report_nonfatal_r <= |(ev_rep & ~sev_r);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // read data is taken in the address phase, so a write still in its
    // data phase to the same word is not seen by a read right behind it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            case (rd_addr)
                ahl_pkg::OFS_HDR_WORD0: begin
                    hrdata_r <= hdr_word_r[0];
                end
                ahl_pkg::OFS_HDR_WORD1: begin
                    hrdata_r <= hdr_word_r[1];
                end
                ahl_pkg::OFS_HDR_WORD2: begin
                    hrdata_r <= hdr_word_r[2];
                end
                ahl_pkg::OFS_HDR_WORD3: begin
                    hrdata_r <= hdr_word_r[3];
                end
                ahl_pkg::OFS_SEC_FLAGS: begin
                    hrdata_r <= {18'h00000, flags_r};
                end
                ahl_pkg::OFS_SEC_MASK: begin
                    hrdata_r <= {18'h00000, mask_r};
                end
                ahl_pkg::OFS_SEC_SEVERITY: begin
                    hrdata_r <= {18'h00000, sev_r};
                end
                ahl_pkg::OFS_SEC_FIRST_PTR: begin
                    hrdata_r <= {27'h0000000, first_ptr_r};
                end
                default: begin
                    hrdata_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign hrdata = hrdata_r;

endmodule

// *** test/ahl_asserts.sv ***
/*
 * Concurrent checks on the ports of the error header log block.
 * Assumes a single master whose hready is the block's hreadyout.
 */
`timescale 1ns/1ps
module ahl_top_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // error events
    input wire logic [13:0] err_event
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ************************************************************
    // transfers
    // ************************************************************
    sequence s_acc(logic w, logic [11:0] a);
        hsel && hready && htrans[1] && hsize == ahl_pkg::HSIZE_WORD && hwrite == w && haddr == a;
    endsequence
    // write, its data phase free of events, then a read of the same word
    sequence s_wr_rd(logic [11:0] a);
        s_acc(1'b1, a) ##1 err_event == 14'h0 ##1 s_acc(1'b0, a);
    endsequence

    // ************************************************************
    // properties
    // ************************************************************
    property p_ready;
        $past(hresetn) |-> hreadyout && hresp == ahl_pkg::HRESP_OKAY;
    endproperty
    property p_set;
        err_event != 14'h0 ##1 s_acc(1'b0, ahl_pkg::OFS_SEC_FLAGS) |=>
            (hrdata[13:0] & $past(err_event, 2) & ahl_pkg::FLAG_SETTABLE)
            == ($past(err_event, 2) & ahl_pkg::FLAG_SETTABLE);
    endproperty
    property p_w1c;
        s_wr_rd(ahl_pkg::OFS_SEC_FLAGS) |=> (hrdata[13:0] & $past(hwdata[13:0], 2)) == 14'h0;
    endproperty
    property p_mask;
        s_wr_rd(ahl_pkg::OFS_SEC_MASK) |=> hrdata == {18'h0, $past(hwdata[13:0], 2) & ahl_pkg::CTRL_WRITABLE};
    endproperty
    property p_sev;
        s_wr_rd(ahl_pkg::OFS_SEC_SEVERITY) |=>
            hrdata == {18'h0, $past(hwdata[13:0], 2) & ahl_pkg::CTRL_WRITABLE};
    endproperty
    property p_ib;
        s_acc(1'b0, ahl_pkg::OFS_SEC_FLAGS) |=> !hrdata[13];
    endproperty
    property p_rsvd;
        s_acc(1'b0, ahl_pkg::OFS_SEC_FLAGS) |=> hrdata[31:14] == 18'h0 && !hrdata[4];
    endproperty
    property p_ptr;
        s_acc(1'b0, ahl_pkg::OFS_SEC_FIRST_PTR) |=> hrdata[31:5] == 27'h0;
    endproperty

    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    a_set: assert property (p_set) else $error("event did not set its flag");
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    a_sev: assert property (p_sev) else $error("severity readback wrong");
    a_ib: assert property (p_ib) else $error("bridge fault bit set");
    a_rsvd: assert property (p_rsvd) else $error("reserved flag bits set");
    a_ptr: assert property (p_ptr) else $error("pointer upper bits set");
endmodule

// *** test/ahl_err_agent.sv ***
/*
 * Model of the secondary bus side: raises error event pulses with a header.
 * Assumes the caller enters fire at a rising edge of hclk.
 */
`timescale 1ns/1ps
module ahl_err_agent (
    // clock
    input wire logic hclk,
    // event side
    output logic [13:0] err_event,
    output logic [127:0] err_header
);
    initial begin
        err_event = 14'h0;
        err_header = 128'h0;
    end
    // returns at the edge that samples the pulse
    task fire(input logic [13:0] ev, input logic [127:0] hdr);
        @(posedge hclk);
        err_event <= ev;
        err_header <= hdr;
        @(posedge hclk);
        err_event <= 14'h0;
        // header no longer valid: show garbage, not the old value
        err_header <= ~hdr;
    endtask
endmodule

// *** test/ahl_top_tb_top.sv ***
/*
 * Self-checking bench of the error header log block over AHB-Lite.
 * Assumes zero or more wait states; waits on hready.
 */
`timescale 1ns/1ps
module ahl_top_tb_top;
    logic hclk, hresetn, hsel, hwrite;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready, hresp, fat, nf;
    wire logic [31:0] hrdata;
    wire logic [13:0] err_event;
    wire logic [127:0] err_header;
    int error_cnt, n_tests, fat_cnt, nf_cnt;
    localparam logic [127:0] HDR_A = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
    localparam logic [127:0] HDR_B = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;

    ahl_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .err_event(err_event), .err_header(err_header),
        .report_fatal_r(fat), .report_nonfatal_r(nf));
    ahl_err_agent u_agent (.hclk(hclk), .err_event(err_event), .err_header(err_header));

    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (fat === 1'b1) fat_cnt++;
        if (nf === 1'b1) nf_cnt++;
    end

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ahl_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= ahl_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask
    task stop_test;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        rd_chk(ahl_pkg::OFS_HDR_WORD0, 32'h0);
        rd_chk(ahl_pkg::OFS_HDR_WORD1, 32'h0);
        rd_chk(ahl_pkg::OFS_HDR_WORD2, 32'h0);
        rd_chk(ahl_pkg::OFS_HDR_WORD3, 32'h0);
        rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0);
        rd_chk(ahl_pkg::OFS_SEC_MASK, 32'h0000_17A8);
        rd_chk(ahl_pkg::OFS_SEC_SEVERITY, 32'h0000_1340);
        rd_chk(ahl_pkg::OFS_SEC_FIRST_PTR, 32'h0);
        rd_chk(12'h200, 32'h0);
    endtask
    task t_hdr;
        u_agent.fire(14'h0800, HDR_A);
        rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0000_0800);
        rd_chk(ahl_pkg::OFS_HDR_WORD0, HDR_A[127:96]);
        rd_chk(ahl_pkg::OFS_HDR_WORD1, HDR_A[95:64]);
        rd_chk(ahl_pkg::OFS_HDR_WORD2, HDR_A[63:32]);
        rd_chk(ahl_pkg::OFS_HDR_WORD3, HDR_A[31:0]);
        rd_chk(ahl_pkg::OFS_SEC_FIRST_PTR, 32'd11);
        chk(32'(nf_cnt), 32'd1);
        wr(ahl_pkg::OFS_HDR_WORD0, 32'hFFFF_FFFF);
        rd_chk(ahl_pkg::OFS_HDR_WORD0, HDR_A[127:96]);
        u_agent.fire(14'h0080, HDR_B);
        rd_chk(ahl_pkg::OFS_HDR_WORD3, HDR_A[31:0]);
        wr(ahl_pkg::OFS_SEC_FLAGS, 32'h0000_0800);
        u_agent.fire(14'h0200, HDR_B);
        rd_chk(ahl_pkg::OFS_HDR_WORD1, HDR_B[95:64]);
        rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0000_0280);
        wr(ahl_pkg::OFS_SEC_FLAGS, 32'hFFFF_FFFF);
        rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0);
    endtask
    task t_flags;
        logic [13:0] ev;
        for (int b = 0; b < 14; b++) begin
            ev = 14'(1 << b);
            u_agent.fire(ev, HDR_B);
            rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'(ev & ahl_pkg::FLAG_SETTABLE));
            wr(ahl_pkg::OFS_SEC_FLAGS, 32'(ev));
            rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0);
        end
        // unmasked at reset: bits 0,1,2,6,11; only bit 6 is fatal by default
        chk(32'(fat_cnt), 32'd1);
        chk(32'(nf_cnt), 32'd5);
    endtask
    task t_ctrl;
        wr(ahl_pkg::OFS_SEC_MASK, 32'hFFFF_FFFF);
        rd_chk(ahl_pkg::OFS_SEC_MASK, 32'h0000_3FEF);
        wr(ahl_pkg::OFS_SEC_SEVERITY, 32'hFFFF_FFFF);
        rd_chk(ahl_pkg::OFS_SEC_SEVERITY, 32'h0000_3FEF);
        u_agent.fire(14'h0040, HDR_A);
        rd_chk(ahl_pkg::OFS_SEC_FLAGS, 32'h0000_0040);
        wr(ahl_pkg::OFS_SEC_FIRST_PTR, 32'hFFFF_FFFF);
        // masked event leaves the last reported position in place
        rd_chk(ahl_pkg::OFS_SEC_FIRST_PTR, 32'd11);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset;
        t_hdr;
        t_flags;
        t_ctrl;
        stop_test;
    end
    // whole run is well under a thousand cycles
    initial begin
        #50000;
        error_cnt++;
        stop_test;
    end
endmodule

bind ahl_top ahl_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_event(err_event));
